// ===== design/gpa_cand_if.sv
/*
  candidate drivers of each port pin, slot 0 highest priority, and the winner.
  assumes the latch always sits in the last slot with its enable set.
*/
interface gpa_cand_if;
    import gpa_pkg::*;

    logic [PIN_N-1:0][SLOT_N-1:0] en;
    logic [PIN_N-1:0][SLOT_N-1:0] val;
    logic [PIN_N-1:0][SLOT_N-1:0] hiz;
    logic [PIN_N-1:0]             win_val;
    logic [PIN_N-1:0]             win_hiz;

    modport src (output en, output val, output hiz, input win_val, input win_hiz);
    modport res (input en, input val, input hiz, output win_val, output win_hiz);

endinterface : gpa_cand_if

// ===== design/gpa_pkg.sv
/*
  constants shared by the port a block: register byte offsets, reset values,
  field positions and the shape of the output priority table.
  assumes a 32-bit avalon-mm slave with byte addresses and one word per register.
*/
package gpa_pkg;

    localparam int          PIN_N      = 8;
    localparam int          SLOT_N     = 5;
    localparam int          LATCH_SLOT = 4;
    localparam int          ANSEL_W    = 6;
    localparam int          ADDR_W     = 5;

    // register byte offsets
    localparam logic [4:0]  OFF_PIN_VALUE = 5'h00;
    localparam logic [4:0]  OFF_DIRECTION = 5'h04;
    localparam logic [4:0]  OFF_LATCH     = 5'h08;
    localparam logic [4:0]  OFF_ANALOG    = 5'h0C;
    localparam logic [4:0]  OFF_PIN_SEL   = 5'h10;

    // reset values and the pin select write mask
    localparam logic [7:0]  DIR_RST   = 8'hFF;
    localparam logic [5:0]  ANSEL_RST = 6'h3F;
    localparam logic [7:0]  PSEL_RST  = 8'h00;
    localparam logic [7:0]  PSEL_MASK = 8'h0E;
    localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

    // pin select fields
    localparam int          SEL_SR_LATCH_INVERTED_OUTPUT_BIT = 3;
    localparam int          SEL_C2_BIT   = 2;
    localparam int          SEL_SS_BIT   = 1;

    // pins that carry the movable functions
    localparam int          PIN_ALT  = 0;
    localparam int          PIN_HOME = 5;

endpackage : gpa_pkg

// ===== design/gpa_port.sv
/*
  eight-pin general purpose port with direction, output latch, analog select,
  alternate pin selects and fixed output priority, behind an avalon-mm slave.
  assumes pins are asynchronous to mclk; peripheral enables and values come
  from logic on mclk; rst is synchronous, active high.
*/
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
module gpa_port
    import gpa_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic [PIN_N-1:0]    pin_i,
    output logic      [PIN_N-1:0]    pin_o,
    output logic      [PIN_N-1:0]    pin_oe_n,
    input  wire logic                pkg_28pin,
    input  wire logic [2:0]          vcap_en,
    input  wire logic                osc_out_en,
    input  wire logic                clk_out_en,
    input  wire logic                clock_output,
    input  wire logic                osc_in_en,
    input  wire logic [PIN_N-1:0]    lcd_en,
    input  wire logic [PIN_N-1:0]    lcd_val,
    input  wire logic                lcd_com3_en,
    input  wire logic                lcd_com3_val,
    input  wire logic                sr_q_en,
    input  wire logic                sr_latch_output,
    input  wire logic                sr_nq_en,
    input  wire logic                sr_latch_inverted_output,
    input  wire logic                comp1_en,
    input  wire logic                comparator1_output,
    input  wire logic                comp2_en,
    input  wire logic                comparator2_output,
    input  wire logic                dac_out_en,
    input  wire logic                capture_compare_5_en,
    input  wire logic                capture_compare_5,
    output logic                     slave_select_in,
    output logic      [PIN_N-1:0]    analog_active
);

    ////////////////////////////////////////////////////////////////////////////
    // pin input synchroniser and digital read path

    logic [PIN_N-1:0]   pin_meta_q;
    logic [PIN_N-1:0]   pin_sync_q;
    logic [PIN_N-1:0]   pin_read;
    logic [PIN_N-1:0]   ansel_full;

    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= pin_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [PIN_N-1:0]   dir_q;
    logic [ANSEL_W-1:0] ansel_q;
    logic [PIN_N-1:0]   psel_q;
    logic [PIN_N-1:0]   latch_q;
    logic               ack_q;
    logic [31:0]        rdata_q;
    logic               wr_go;
    logic               be0;
    logic [31:0]        rd_mux;

    assign ansel_full    = {{(PIN_N - ANSEL_W){1'b0}}, ansel_q};
    assign pin_read      = pin_sync_q & ~ansel_full;
    assign analog_active = ansel_full;

    // one wait state: the request is seen, then answered on the next edge
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_go           = avs_write & ack_q;
    assign be0             = avs_byteenable[0];
    assign avs_readdata    = rdata_q;

    always_comb begin
        case (avs_address)
            OFF_PIN_VALUE: rd_mux = {24'h00_0000, pin_read};
            OFF_DIRECTION: rd_mux = {24'h00_0000, dir_q};
            OFF_LATCH:     rd_mux = {24'h00_0000, latch_q};
            OFF_ANALOG:    rd_mux = {24'h00_0000, ansel_full};
            OFF_PIN_SEL:   rd_mux = {24'h00_0000, psel_q};
            default:       rd_mux = RD_ZERO;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_q   <= 1'b0;
            rdata_q <= RD_ZERO;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
            if (avs_read && !ack_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            dir_q <= DIR_RST;
        end else if (wr_go && be0 && avs_address == OFF_DIRECTION) begin
            dir_q <= avs_writedata[PIN_N-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ansel_q <= ANSEL_RST;
        end else if (wr_go && be0 && avs_address == OFF_ANALOG) begin
            ansel_q <= avs_writedata[ANSEL_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            psel_q <= PSEL_RST;
        end else if (wr_go && be0 && avs_address == OFF_PIN_SEL) begin
            psel_q <= avs_writedata[PIN_N-1:0] & PSEL_MASK;
        end
    end

    // the latch has no reset: its content survives every reset
    always_ff @(posedge mclk) begin
        if (wr_go && avs_address == OFF_LATCH && be0) begin
            latch_q <= avs_writedata[PIN_N-1:0];
        end else if (wr_go && avs_address == OFF_PIN_VALUE) begin
            // pins are read, the addressed byte replaced, all of it stored;
            // analog pins read zero, so without byteenable[0] their latch bits get cleared here
            latch_q <= be0 ? avs_writedata[PIN_N-1:0] : pin_read;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output priority and pin drive

    gpa_cand_if cand ();

    logic sel_sr;
    logic sel_c2;

    assign sel_sr = psel_q[SEL_SR_LATCH_INVERTED_OUTPUT_BIT];
    assign sel_c2 = psel_q[SEL_C2_BIT];

    // functions marked hiz claim the pin but leave the digital driver off
    always_comb begin
        cand.en  = '0;
        cand.val = '0;
        cand.hiz = '0;
        for (int p = 0; p < PIN_N; p++) begin
            cand.en[p][LATCH_SLOT]  = 1'b1;
            cand.val[p][LATCH_SLOT] = latch_q[p];
        end
        // pin 0
        cand.en[0][0]  = vcap_en[0];
        cand.hiz[0][0] = 1'b1;
        cand.en[0][1]  = lcd_en[0];
        cand.val[0][1] = lcd_val[0];
        cand.en[0][2]  = sr_nq_en & sel_sr;
        cand.val[0][2] = sr_latch_inverted_output;
        cand.en[0][3]  = comp2_en & sel_c2;
        cand.val[0][3] = comparator2_output;
        // pin 1
        cand.en[1][0]  = lcd_en[1];
        cand.val[1][0] = lcd_val[1];
        // pin 2: lcd common 2 then dac
        cand.en[2][0]  = lcd_en[2];
        cand.val[2][0] = lcd_val[2];
        cand.en[2][1]  = dac_out_en;
        cand.hiz[2][1] = 1'b1;
        // pin 3
        cand.en[3][0]  = lcd_com3_en & pkg_28pin;
        cand.val[3][0] = lcd_com3_val;
        cand.en[3][1]  = lcd_en[3];
        cand.val[3][1] = lcd_val[3];
        // pin 4
        cand.en[4][0]  = lcd_en[4];
        cand.val[4][0] = lcd_val[4];
        cand.en[4][1]  = sr_q_en;
        cand.val[4][1] = sr_latch_output;
        cand.en[4][2]  = comp1_en;
        cand.val[4][2] = comparator1_output;
        cand.en[4][3]  = capture_compare_5_en & pkg_28pin;
        cand.val[4][3] = capture_compare_5;
        // pin 5
        cand.en[5][0]  = vcap_en[1];
        cand.hiz[5][0] = 1'b1;
        cand.en[5][1]  = lcd_en[5];
        cand.val[5][1] = lcd_val[5];
        cand.en[5][2]  = sr_nq_en & ~sel_sr;
        cand.val[5][2] = sr_latch_inverted_output;
        cand.en[5][3]  = comp2_en & ~sel_c2;
        cand.val[5][3] = comparator2_output;
        // pin 6
        cand.en[6][0]  = vcap_en[2];
        cand.hiz[6][0] = 1'b1;
        cand.en[6][1]  = osc_out_en;
        cand.hiz[6][1] = 1'b1;
        cand.en[6][2]  = clk_out_en;
        cand.val[6][2] = clock_output;
        cand.en[6][3]  = lcd_en[6];
        cand.val[6][3] = lcd_val[6];
        // pin 7
        cand.en[7][0]  = osc_in_en;
        cand.hiz[7][0] = 1'b1;
        cand.en[7][1]  = lcd_en[7];
        cand.val[7][1] = lcd_val[7];
    end

    gpa_prio u_prio (
        .cand (cand)
    );

    // analog select takes no part here: digital drive depends on direction and the winner's hiz flag
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_oe_n <= {PIN_N{1'b1}};
            pin_o    <= '0;
        end else begin
            pin_oe_n <= dir_q | cand.win_hiz;
            pin_o    <= ~(dir_q | cand.win_hiz) & cand.win_val;
        end
    end

    assign slave_select_in = psel_q[SEL_SS_BIT] ? pin_read[PIN_ALT]
                                                : pin_read[PIN_HOME];

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence rd_pin_s;
        avs_read && !ack_q && avs_address == OFF_PIN_VALUE ##1 avs_read && ack_q;
    endsequence

    sequence wr_pin_nobe_s;
        avs_write && ack_q && avs_address == OFF_PIN_VALUE && !be0;
    endsequence

    dir_reset_a: assert property ($fell(rst) |-> dir_q == DIR_RST)
        else $error("direction not all inputs after reset");

    ansel_reset_a: assert property ($fell(rst) |-> ansel_q == ANSEL_RST)
        else $error("analog select not analog after reset");

    // the driver follows direction one edge later, so compare against last cycle's bits
    input_hiz_a: assert property (##1 (($past(dir_q) & ~pin_oe_n) == '0))
        else $error("input pin is being driven");

    latch_drive_a: assert property (!dir_q[1] && !lcd_en[1]
        |=> !pin_oe_n[1] && pin_o[1] == $past(latch_q[1]))
        else $error("output pin does not show latch");

    rd_pin_a: assert property (rd_pin_s |-> avs_readdata[PIN_N-1:0] == $past(pin_read))
        else $error("pin read does not return pins");

    wr_latch_a: assert property (avs_write && ack_q && avs_address == OFF_PIN_VALUE && be0
        |=> latch_q == $past(avs_writedata[PIN_N-1:0]))
        else $error("pin write did not reach latch");

    rmw_a: assert property (wr_pin_nobe_s |=> latch_q == $past(pin_read))
        else $error("read-modify-write lost pin levels");

    analog_read_a: assert property ((pin_read & ansel_full) == '0)
        else $error("analog pin reads one");

    vcap_prio_a: assert property (vcap_en[0] |=> pin_oe_n[0])
        else $error("regulator pin still driven");

    seg_prio_a: assert property (lcd_en[4] && !dir_q[4] && sr_q_en
        |=> !pin_oe_n[4] && pin_o[4] == $past(lcd_val[4]))
        else $error("pin 4 priority broken");

    clock_output_prio_a: assert property (clk_out_en && !osc_out_en && !vcap_en[2] && !dir_q[6]
        |=> pin_o[6] == $past(clock_output))
        else $error("pin 6 clock output lost");

    sr_latch_inverted_output_route_a: assert property (sr_nq_en && !sel_sr && !vcap_en[1] && !lcd_en[5]
        && !dir_q[5] |=> pin_o[5] == $past(sr_latch_inverted_output))
        else $error("sr inverted output not on pin 5");

    c2_route_a: assert property (comp2_en && sel_c2 && !vcap_en[0] && !lcd_en[0] && !sr_nq_en
        && !dir_q[0] |=> pin_o[0] == $past(comparator2_output))
        else $error("comparator 2 not on pin 0");

    ss_route_a: assert property (!psel_q[SEL_SS_BIT] && !ansel_full[PIN_HOME]
        |-> slave_select_in == pin_sync_q[PIN_HOME])
        else $error("slave select from wrong pin");

    analog_drive_a: assert property (ansel_q[1] && !dir_q[1] && !lcd_en[1]
        |=> !pin_oe_n[1])
        else $error("analog select blocked digital output");

endmodule : gpa_port

// ===== design/gpa_prio.sv
/*
  fixed priority resolver: for every pin the enabled slot with the lowest
  index wins. assumes slot LATCH_SLOT is always enabled, so a winner exists.
*/
module gpa_prio
    import gpa_pkg::*;
(
    gpa_cand_if.res cand
);

    for (genvar p = 0; p < PIN_N; p++) begin : g_pin
        logic wv;
        logic wh;

        always_comb begin
            wv = 1'b0;
            wh = 1'b0;
            // walk upward in priority so the highest enabled slot is taken last
            for (int k = SLOT_N - 1; k >= 0; k--) begin
                if (cand.en[p][k]) begin
                    wv = cand.val[p][k];
                    wh = cand.hiz[p][k];
                end
            end
        end

        assign cand.win_val[p] = wv;
        assign cand.win_hiz[p] = wh;
    end

endmodule : gpa_prio

// ===== verification/gpa_ext_model.sv
/*
  external circuitry on the eight port pins: resolves the level of each wire.
  assumes pin_o and pin_oe_n come from the port, and ext_en/ext_val from the bench.
*/
module gpa_ext_model
    import gpa_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic [PIN_N-1:0] pin_o,
    input  wire logic [PIN_N-1:0] pin_oe_n,
    input  wire logic [PIN_N-1:0] ext_en,
    input  wire logic [PIN_N-1:0] ext_val,
    output logic      [PIN_N-1:0] pin_i
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [PIN_N-1:0] float_q = 8'h55;

    // no pull on these pins, so a floating wire never holds a stale level
    always_ff @(posedge mclk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < PIN_N; i++) begin
            if (!pin_oe_n[i]) pin_i[i] = pin_o[i];
            else if (ext_en[i]) pin_i[i] = ext_val[i];
            else pin_i[i] = float_q[i];
        end
    end

endmodule : gpa_ext_model

// ===== verification/gpa_port_tb.sv
/*
  self-checking bench for the port: avalon-mm register tasks, pin and priority checks.
  assumes gpa_port and gpa_ext_model; one 100 MHz clock, synchronous reset.
*/
module gpa_port_tb;
    import gpa_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic              mclk, rst, avs_read, avs_write, avs_waitrequest, slave_select_in;
    logic [ADDR_W-1:0] avs_address;
    logic [31:0]       avs_writedata, avs_readdata;
    logic [3:0]        avs_byteenable;
    logic [PIN_N-1:0]  pin_i, pin_o, pin_oe_n, analog_active, ext_en, ext_val;
    logic [PIN_N-1:0]  lcd_en, lcd_val;
    logic [2:0]        vcap_en;
    logic              pkg_28pin, osc_out_en, clk_out_en, clock_output, osc_in_en;
    logic              lcd_com3_en, lcd_com3_val, sr_q_en, sr_latch_output, sr_nq_en;
    logic              sr_latch_inverted_output, comp1_en, comparator1_output, comp2_en;
    logic              comparator2_output, dac_out_en, capture_compare_5_en, capture_compare_5;
    logic [7:0]        rd_q, s;
    logic [1:0]        e;
    int                fails, compares, p;

    gpa_port DUT (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_i, .pin_o, .pin_oe_n,
        .pkg_28pin, .vcap_en, .osc_out_en, .clk_out_en, .clock_output, .osc_in_en,
        .lcd_en, .lcd_val, .lcd_com3_en, .lcd_com3_val, .sr_q_en, .sr_latch_output,
        .sr_nq_en, .sr_latch_inverted_output, .comp1_en, .comparator1_output, .comp2_en,
        .comparator2_output, .dac_out_en, .capture_compare_5_en, .capture_compare_5,
        .slave_select_in, .analog_active);

    gpa_ext_model ext (.mclk, .pin_o, .pin_oe_n, .ext_en, .ext_val, .pin_i);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        compares++;
        if (got !== ex) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : wait_cyc

    // waitrequest and readdata are read at the rising edge, before its updates land
    task automatic bus_wait();
        int n;
        n = 0;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 50) fails++;
        rd_q = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus_wait

    task automatic bus_wr(input logic [4:0] a, input logic [7:0] d, input logic be0);
        @(posedge mclk);
        avs_address    <= a;
        avs_writedata  <= {24'h00_0000, d};
        avs_byteenable <= {3'h0, be0};
        avs_write      <= 1'b1;
        bus_wait();
    endtask : bus_wr

    task automatic rdc(input logic [4:0] a, input logic [7:0] ex, input string nm);
        @(posedge mclk);
        avs_address <= a;
        avs_read    <= 1'b1;
        bus_wait();
        chk(nm, ex, rd_q);
    endtask : rdc

    // called at a rising edge: the value copied is the level that stood all last cycle
    task automatic pchk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        chk(nm, ex, got);
    endtask : pchk

    task automatic clr();
        {lcd_en, lcd_val, vcap_en} <= '0;
        {pkg_28pin, osc_out_en, clk_out_en, clock_output, osc_in_en} <= '0;
        {lcd_com3_en, lcd_com3_val, sr_q_en, sr_latch_output, sr_nq_en} <= '0;
        {sr_latch_inverted_output, comp1_en, comparator1_output, comp2_en} <= '0;
        {comparator2_output, dac_out_en, capture_compare_5_en, capture_compare_5} <= '0;
    endtask : clr

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        print_verdict();
    end

    initial begin
        fails = 0;
        compares = 0;
        rst <= 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} <= '0;
        ext_en  <= 8'h00;
        ext_val <= 8'h00;
        clr();
        wait_cyc(20);
        rst <= 1'b0;
        rdc(OFF_DIRECTION, 8'hFF, "direction");
        rdc(OFF_ANALOG, 8'h3F, "analog");
        rdc(OFF_PIN_SEL, 8'h00, "pin_sel");
        rdc(5'h14, 8'h00, "unmapped");
        pchk("oe_n", 8'hFF, pin_oe_n);
        pchk("analog_active", 8'h3F, analog_active);
        bus_wr(OFF_PIN_SEL, 8'hFF, 1'b1);
        rdc(OFF_PIN_SEL, 8'h0E, "pin_sel");
        $display("test reset done");
        ext_en  <= 8'hFF;
        ext_val <= 8'hFF;
        wait_cyc(4);
        rdc(OFF_PIN_VALUE, 8'hC0, "pin_value");
        bus_wr(OFF_ANALOG, 8'h00, 1'b1);
        ext_val <= 8'h5A;
        wait_cyc(4);
        rdc(OFF_PIN_VALUE, 8'h5A, "pin_value");
        $display("test input done");
        // outside drive is removed before the port drives, avoiding contention
        ext_en <= 8'h00;
        bus_wr(OFF_LATCH, 8'hA5, 1'b1);
        bus_wr(OFF_DIRECTION, 8'h00, 1'b1);
        wait_cyc(3);
        pchk("oe_n", 8'h00, pin_oe_n);
        pchk("pin_o", 8'hA5, pin_o);
        rdc(OFF_PIN_VALUE, 8'hA5, "pin_value");
        bus_wr(OFF_ANALOG, 8'h3F, 1'b1);
        wait_cyc(3);
        pchk("pin_o", 8'hA5, pin_o);
        pchk("oe_n", 8'h00, pin_oe_n);
        rdc(OFF_PIN_VALUE, 8'h80, "pin_value");
        bus_wr(OFF_PIN_VALUE, 8'h00, 1'b0);
        rdc(OFF_LATCH, 8'h80, "latch");
        bus_wr(OFF_PIN_VALUE, 8'h3C, 1'b1);
        rdc(OFF_LATCH, 8'h3C, "latch");
        wait_cyc(2);
        pchk("pin_o", 8'h3C, pin_o);
        bus_wr(OFF_DIRECTION, 8'hFF, 1'b1);
        wait_cyc(3);
        pchk("oe_n", 8'hFF, pin_oe_n);
        $display("test drive done");
        bus_wr(OFF_ANALOG, 8'h00, 1'b1);
        bus_wr(OFF_LATCH, 8'h00, 1'b1);
        bus_wr(OFF_DIRECTION, 8'h00, 1'b1);
        for (int i = 0; i < 21; i++) begin
            wait_cyc(1);
            clr();
            wait_cyc(1);
            s = 8'h00;
            e = 2'b01;
            case (i)
                0: begin s = 8'h0C; p = 0; {lcd_en, lcd_val, sr_nq_en, comp2_en} <= 18'h0_0407; end
                1: begin s = 8'h0C; p = 0; {sr_nq_en, sr_latch_inverted_output, comp2_en} <= 3'h7; end
                2: begin s = 8'h04; p = 0; {comp2_en, comparator2_output} <= 2'h3; end
                3: begin s = 8'h0C; p = 0; e = 2'b10; {vcap_en, lcd_en} <= 11'h101; end
                4: begin p = 5; {comp2_en, comparator2_output} <= 2'h3; end
                5: begin p = 5; {sr_nq_en, sr_latch_inverted_output, comp2_en} <= 3'h7; end
                6: begin s = 8'h08; p = 5; e = 2'b00; {sr_nq_en, sr_latch_inverted_output} <= 2'h3; end
                7: begin p = 5; e = 2'b10; {vcap_en, lcd_en, lcd_val} <= 19'h2_2020; end
                8: begin p = 1; {lcd_en, lcd_val} <= 16'h0202; end
                9: begin p = 2; {lcd_en, lcd_val, dac_out_en} <= 17'h0_0809; end
                10: begin p = 3; {pkg_28pin, lcd_com3_en, lcd_com3_val, lcd_en} <= 11'h708; end
                11: begin p = 3; e = 2'b00; {lcd_com3_en, lcd_com3_val, lcd_en} <= 10'h308; end
                12: begin p = 4; {sr_q_en, sr_latch_output, comp1_en} <= 3'h7; end
                13: begin p = 4; {pkg_28pin, comp1_en, comparator1_output, capture_compare_5_en} <= 4'hF; end
                14: begin p = 4; {pkg_28pin, capture_compare_5_en, capture_compare_5} <= 3'h7; end
                15: begin p = 4; e = 2'b00; {capture_compare_5_en, capture_compare_5} <= 2'h3; end
                16: begin p = 6; {clk_out_en, clock_output, lcd_en} <= 10'h340; end
                17: begin p = 7; e = 2'b10; {osc_in_en, lcd_en, lcd_val} <= 17'h1_8080; end
                18: begin p = 4; {lcd_en, lcd_val, sr_q_en, sr_latch_output} <= 18'h0_4042; end
                19: begin p = 6; e = 2'b10; {osc_out_en, clk_out_en, clock_output} <= 3'h7; end
                default: begin p = 7; {lcd_en, lcd_val} <= 16'h8080; end
            endcase
            bus_wr(OFF_PIN_SEL, s, 1'b1);
            wait_cyc(3);
            pchk("prio", {6'h00, e}, {6'h00, pin_oe_n[p], pin_o[p]});
        end
        wait_cyc(1);
        clr();
        $display("test priority done");
        bus_wr(OFF_DIRECTION, 8'hFF, 1'b1);
        ext_en  <= 8'hFF;
        ext_val <= 8'h01;
        bus_wr(OFF_PIN_SEL, 8'h00, 1'b1);
        wait_cyc(4);
        pchk("slave_select", 8'h00, {7'h00, slave_select_in});
        wait_cyc(1);
        bus_wr(OFF_PIN_SEL, 8'h02, 1'b1);
        wait_cyc(2);
        pchk("slave_select", 8'h01, {7'h00, slave_select_in});
        $display("test slave select done");
        bus_wr(OFF_LATCH, 8'h96, 1'b1);
        bus_wr(OFF_DIRECTION, 8'h0F, 1'b1);
        rst <= 1'b1;
        wait_cyc(2);
        rst <= 1'b0;
        rdc(OFF_LATCH, 8'h96, "latch");
        rdc(OFF_DIRECTION, 8'hFF, "direction");
        rdc(OFF_ANALOG, 8'h3F, "analog");
        $display("test second reset done");
        print_verdict();
    end

endmodule : gpa_port_tb
